// *** verilog/intc_defines.svh ***
/*
 Offsets, field positions, sizes and cycle counts of the
 interrupt and event transfer system. Assumes a 16-bit register port.
*/
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH

// Sizes
`define N_NODES 112
`define N_DED 104
`define N_SHARED 8
`define N_CH 8
`define N_TRAP 8

// Register offsets
`define A_NODE_LAST 8'h6F
`define A_SEL_BASE 8'h70
`define A_CH_BASE 8'h80
`define A_CH_LAST 8'h9F
`define A_TRAP 8'hA0
`define A_ESR 8'hA1
`define A_EDGE 8'hA2
`define A_ROUTE 8'hA3
`define A_PATT 8'hA4
`define A_GATE 8'hA5
`define A_STAT 8'hA6
`define A_MASK 8'hA7
`define A_CORE 8'hA8

// Node control fields
`define NODE_PRIO 3:0
`define NODE_EN 6
`define NODE_REQ 7
`define NODE_XSEL 8
`define NODE_CH 11:9

// Channel control fields and field offsets
`define CH_BYTE 0
`define CH_INCS 1
`define CH_INCD 2
`define CH_CONT 3
`define CF_CTL 2'h0
`define CF_CNT 2'h1
`define CF_SRC 2'h2
`define CF_DST 2'h3

// Trap flags driven by the service request pins, and the trap vector base
`define TRAP_SR0 6
`define TRAP_SR1 7
`define TRAP_VEC 8'h80

// Gating modes
`define G_OFF 2'h0
`define G_ANY 2'h1
`define G_MATCH 2'h2
`define G_MISS 2'h3

// Request to service latency in clocks
`define LAT_JC 4'h7
`define LAT_NOJC 4'hB
`define LAT_SKEW 4'h2

`endif

// *** verilog/intc_pkg.sv ***
/*
 Types of the interrupt and event transfer system: service state and
 the complete register state of the block. Assumes intc_defines.svh.
*/
`default_nettype none
`include "intc_defines.svh"
package intc_pkg;

    typedef enum logic [1:0] {IDLE, WAIT, SERVE} svc_state_t;

    typedef struct packed {
        logic [`N_NODES-1:0] req;
        logic [`N_NODES-1:0] en;
        logic [`N_NODES-1:0][3:0] prio;
        logic [`N_NODES-1:0] xsel;
        logic [`N_NODES-1:0][2:0] chn;
        logic [`N_SHARED-1:0][3:0] sel;
        logic [`N_CH-1:0][3:0] cctl;
        logic [`N_CH-1:0][7:0] ccnt;
        logic [`N_CH-1:0][15:0] csrc;
        logic [`N_CH-1:0][15:0] cdst;
        logic [`N_TRAP-1:0] trap_flag_register;
        logic tact;
        logic [2:0] tlvl;
        logic [5:0] esr_cfg;
        logic [2:0] esr_s1;
        logic [2:0] esr_s2;
        logic [2:0] esr_d;
        logic [7:0] edge_cfg;
        logic [15:0] route;
        logic [15:0] patt;
        logic [7:0] gate;
        logic [3:0] eru_s1;
        logic [3:0] eru_s2;
        logic [3:0] eru_d;
        logic [7:0] stat;
        logic [7:0] mask;
        svc_state_t st;
        logic [3:0] cnt;
        logic [6:0] node;
        logic std;
        logic clr;
        logic [7:0] vec;
        logic [15:0] xsrc;
        logic [15:0] xdst;
        logic xbyte;
        logic soft_pend;
        logic [6:0] soft_num;
        logic [15:0] rdata;
    } intc_state_t;

endpackage
`default_nettype wire

// *** verilog/interrupt_and_event_transfer_system.sv ***
/*
 Interrupt nodes, event transfer channels, external request router,
 trap flags, service request pins and software traps.
 Assumes a CPU core on clock_in and request pulses on the same clock;
 router and service request pins are asynchronous.
*/
// Design decisions made here: strobed register access and the address map.
// Overview of operation
// - Each node is served by the controller or by a transfer channel.
// - Standard service gives a branch pulse with the node vector.
// - A transfer takes one stolen cycle and gives no branch.
// - A transfer moves byte or word, then bumps pointers as set.
// - Transfer count drops per service unless continuous mode is set.
// - Count reaching zero turns the request into a standard interrupt.
// - Eight independent transfer channels, each started by a request.
// - Request to service start takes 7 clocks, or 11 without cache.
// - 112 nodes, each with request flag, enable flag and priority.
// - Source select registers pick the source of each shared node.
// - Four router inputs detect rising, falling or both edges.
// - Routing matrix and four gates filter events by pattern.
// - Each hardware trap sets its own flag and own vector.
// - A trap preempts anything but the same or a higher trap in service.
// - Trap service is not preempted by interrupts or transfers.
// - Three service request pins drive two system request traps.
// - Writing the request flag raises the node like hardware.
// - Software trap vectors straight to the numbered routine.
`timescale 1ns/1ps
`default_nettype none
`include "intc_defines.svh"
module interrupt_and_event_transfer_system (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // Request sources
    input wire logic [`N_DED-1:0] src_req_in,
    input wire logic [11:0] shared_src_in,
    input wire logic [3:0] eru_pin_in,
    input wire logic [2:0] esr_pin_in,
    // CPU side
    input wire logic [3:0] cpu_level_in,
    input wire logic jump_cache_in,
    input wire logic [5:0] trap_in,
    input wire logic trap_ret_in,
    input wire logic soft_trap_in,
    input wire logic [6:0] soft_trap_num_in,
    // Service outputs
    output logic branch_out,
    output logic [7:0] vector_out,
    output logic trap_active_out,
    output logic xfer_out,
    output logic [15:0] xfer_src_out,
    output logic [15:0] xfer_dst_out,
    output logic xfer_byte_out,
    output logic irq_out
);

    intc_pkg::intc_state_t r_reg, r_next;

    logic [`N_NODES-1:0] hw;
    logic [15:0] pool;
    logic [3:0] rise, fall, evt, output_gating_unit, rt;
    logic [2:0] esr_e;
    logic sr0, sr1, hit, pm, found, tfound;
    logic [3:0] best_p;
    logic [6:0] best;
    logic [2:0] tidx, ch, wch;
    logic [6:0] wn;
    logic [15:0] inc;
    logic [7:0] dec;

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata_out = r_reg.rdata;
    assign branch_out = r_reg.st == intc_pkg::SERVE && r_reg.std;
    assign xfer_out = r_reg.st == intc_pkg::SERVE && !r_reg.std;
    assign vector_out = r_reg.vec;
    assign trap_active_out = r_reg.tact;
    assign xfer_src_out = r_reg.xsrc;
    assign xfer_dst_out = r_reg.xdst;
    assign xfer_byte_out = r_reg.xbyte;
    assign irq_out = |(r_reg.stat & r_reg.mask);

    ////////////////////////////////////////////////////////////////////
    // Next state of the whole block
    always_comb begin
        r_next = r_reg;
        wn = reg_addr_in[6:0];
        wch = reg_addr_in[4:2];
        // Synchronisers and edge history
        r_next.eru_s1 = eru_pin_in;
        r_next.eru_s2 = r_reg.eru_s1;
        r_next.eru_d = r_reg.eru_s2;
        r_next.esr_s1 = esr_pin_in;
        r_next.esr_s2 = r_reg.esr_s1;
        r_next.esr_d = r_reg.esr_s2;
        // Edge trigger logic per input
        rise = r_reg.eru_s2 & ~r_reg.eru_d;
        fall = ~r_reg.eru_s2 & r_reg.eru_d;
        evt = '0;
        output_gating_unit = '0;
        rt = '0;
        hit = 1'b0;
        pm = 1'b0;
        for (int k = 0; k < 4; k++) begin
            evt[k] = (rise[k] & r_reg.edge_cfg[2*k]) |
                     (fall[k] & r_reg.edge_cfg[2*k+1]);
        end
        // Routing matrix and output gating units
        for (int j = 0; j < 4; j++) begin
            rt = r_reg.route[4*j +: 4];
            hit = |(evt & rt);
            pm = ((r_reg.eru_s2 ^ r_reg.patt[4*j +: 4]) & rt) == 4'h0;
            case (r_reg.gate[2*j +: 2])
                `G_ANY: output_gating_unit[j] = hit;
                `G_MATCH: output_gating_unit[j] = hit & pm;
                `G_MISS: output_gating_unit[j] = hit & ~pm;
                default: output_gating_unit[j] = 1'b0;
            endcase
        end
        // Shared node source selection
        pool = {output_gating_unit, shared_src_in};
        hw = '0;
        hw[`N_DED-1:0] = src_req_in;
        for (int i = 0; i < `N_SHARED; i++) begin
            hw[`N_DED+i] = pool[r_reg.sel[i]];
        end
        // Service request pins to system requests
        esr_e = r_reg.esr_s2 & ~r_reg.esr_d;
        sr0 = |(esr_e & r_reg.esr_cfg[2:0]);
        sr1 = |(esr_e & r_reg.esr_cfg[5:3]);
        // Priority arbitration over enabled pending nodes
        found = 1'b0;
        best = '0;
        best_p = cpu_level_in;
        for (int i = 0; i < `N_NODES; i++) begin
            if (r_reg.req[i] && r_reg.en[i] && r_reg.prio[i] > best_p) begin
                found = 1'b1;
                best = 7'(i);
                best_p = r_reg.prio[i];
            end
        end
        // Highest pending trap flag
        tfound = 1'b0;
        tidx = '0;
        for (int i = 0; i < `N_TRAP; i++) begin
            if (r_reg.trap_flag_register[i]) begin
                tfound = 1'b1;
                tidx = 3'(i);
            end
        end
        ch = r_reg.chn[r_reg.node];
        inc = r_reg.cctl[ch][`CH_BYTE] ? 16'h0001 : 16'h0002;
        dec = r_reg.ccnt[ch] - 8'h01;
        // Service sequencer
        case (r_reg.st)
            intc_pkg::IDLE: begin
                if (tfound && (!r_reg.tact || tidx > r_reg.tlvl)) begin
                    r_next.st = intc_pkg::SERVE;
                    r_next.vec = `TRAP_VEC | {5'h00, tidx};
                    r_next.tact = 1'b1;
                    r_next.tlvl = tidx;
                    r_next.std = 1'b1;
                    r_next.clr = 1'b0;
                end else if (r_reg.soft_pend) begin
                    r_next.st = intc_pkg::SERVE;
                    r_next.vec = {1'b0, r_reg.soft_num};
                    r_next.soft_pend = 1'b0;
                    r_next.std = 1'b1;
                    r_next.clr = 1'b0;
                end else if (found && !r_reg.tact) begin
                    r_next.st = intc_pkg::WAIT;
                    r_next.cnt = (jump_cache_in ? `LAT_JC : `LAT_NOJC)
                                 - `LAT_SKEW;
                    r_next.node = best;
                    r_next.clr = 1'b1;
                    r_next.std = !r_reg.xsel[best] ||
                        (r_reg.ccnt[r_reg.chn[best]] == 8'h00 &&
                         !r_reg.cctl[r_reg.chn[best]][`CH_CONT]);
                end
            end
            intc_pkg::WAIT: begin
                r_next.cnt = r_reg.cnt - 4'h1;
                if (r_reg.cnt == 4'h0) begin
                    r_next.st = intc_pkg::SERVE;
                    r_next.vec = {1'b0, r_reg.node};
                    r_next.xsrc = r_reg.csrc[ch];
                    r_next.xdst = r_reg.cdst[ch];
                    r_next.xbyte = r_reg.cctl[ch][`CH_BYTE];
                end
            end
            intc_pkg::SERVE: begin
                r_next.st = intc_pkg::IDLE;
                if (r_reg.clr) begin
                    r_next.req[r_reg.node] = 1'b0;
                end
                if (r_reg.clr && !r_reg.std) begin
                    if (r_reg.cctl[ch][`CH_INCS]) begin
                        r_next.csrc[ch] = r_reg.csrc[ch] + inc;
                    end
                    if (r_reg.cctl[ch][`CH_INCD]) begin
                        r_next.cdst[ch] = r_reg.cdst[ch] + inc;
                    end
                    if (!r_reg.cctl[ch][`CH_CONT]) begin
                        r_next.ccnt[ch] = dec;
                        if (dec == 8'h00) begin
                            r_next.req[r_reg.node] = 1'b1;
                            r_next.xsel[r_reg.node] = 1'b0;
                            r_next.stat[ch] = 1'b1;
                        end
                    end
                end
            end
            default: r_next.st = intc_pkg::IDLE;
        endcase
        if (trap_ret_in) begin
            r_next.tact = 1'b0;
        end
        // Register writes
        if (reg_wr_in) begin
            if (reg_addr_in <= `A_NODE_LAST) begin
                r_next.prio[wn] = reg_wdata_in[`NODE_PRIO];
                r_next.en[wn] = reg_wdata_in[`NODE_EN];
                r_next.req[wn] = reg_wdata_in[`NODE_REQ];
                r_next.xsel[wn] = reg_wdata_in[`NODE_XSEL];
                r_next.chn[wn] = reg_wdata_in[`NODE_CH];
            end else if (reg_addr_in < `A_CH_BASE) begin
                r_next.sel[reg_addr_in[2:0]] = reg_wdata_in[3:0];
            end else if (reg_addr_in <= `A_CH_LAST) begin
                case (reg_addr_in[1:0])
                    `CF_CTL: r_next.cctl[wch] = reg_wdata_in[3:0];
                    `CF_CNT: r_next.ccnt[wch] = reg_wdata_in[7:0];
                    `CF_SRC: r_next.csrc[wch] = reg_wdata_in;
                    default: r_next.cdst[wch] = reg_wdata_in;
                endcase
            end else begin
                case (reg_addr_in)
                    `A_TRAP: r_next.trap_flag_register = r_reg.trap_flag_register & ~reg_wdata_in[7:0];
                    `A_ESR: r_next.esr_cfg = reg_wdata_in[5:0];
                    `A_EDGE: r_next.edge_cfg = reg_wdata_in[7:0];
                    `A_ROUTE: r_next.route = reg_wdata_in;
                    `A_PATT: r_next.patt = reg_wdata_in;
                    `A_GATE: r_next.gate = reg_wdata_in[7:0];
                    `A_MASK: r_next.mask = reg_wdata_in[7:0];
                    default: r_next.mask = r_next.mask;
                endcase
            end
        end
        // Register reads, status cleared by its read
        r_next.rdata = 16'h0000;
        if (reg_rd_in) begin
            if (reg_addr_in <= `A_NODE_LAST) begin
                r_next.rdata = {4'h0, r_reg.chn[wn], r_reg.xsel[wn],
                    r_reg.req[wn], r_reg.en[wn], 2'h0, r_reg.prio[wn]};
            end else if (reg_addr_in < `A_CH_BASE) begin
                r_next.rdata = {12'h000, r_reg.sel[reg_addr_in[2:0]]};
            end else if (reg_addr_in <= `A_CH_LAST) begin
                case (reg_addr_in[1:0])
                    `CF_CTL: r_next.rdata = {12'h000, r_reg.cctl[wch]};
                    `CF_CNT: r_next.rdata = {8'h00, r_reg.ccnt[wch]};
                    `CF_SRC: r_next.rdata = r_reg.csrc[wch];
                    default: r_next.rdata = r_reg.cdst[wch];
                endcase
            end else begin
                case (reg_addr_in)
                    `A_TRAP: r_next.rdata = {8'h00, r_reg.trap_flag_register};
                    `A_ESR: r_next.rdata = {10'h000, r_reg.esr_cfg};
                    `A_EDGE: r_next.rdata = {8'h00, r_reg.edge_cfg};
                    `A_ROUTE: r_next.rdata = r_reg.route;
                    `A_PATT: r_next.rdata = r_reg.patt;
                    `A_GATE: r_next.rdata = {8'h00, r_reg.gate};
                    `A_STAT: begin
                        r_next.rdata = {8'h00, r_reg.stat};
                        r_next.stat = 8'h00;
                    end
                    `A_MASK: r_next.rdata = {8'h00, r_reg.mask};
                    `A_CORE: r_next.rdata = {8'h00, r_reg.tact,
                        r_reg.tlvl, 2'h0, r_reg.st};
                    default: r_next.rdata = 16'h0000;
                endcase
            end
        end
        // Sets win over clears
        if (r_reg.st == intc_pkg::SERVE && r_reg.clr && !r_reg.std &&
            !r_reg.cctl[ch][`CH_CONT] && dec == 8'h00) begin
            r_next.stat[ch] = 1'b1;
        end
        r_next.req = r_next.req | hw;
        r_next.trap_flag_register = r_next.trap_flag_register | {sr1, sr0, trap_in};
        if (soft_trap_in) begin
            r_next.soft_pend = 1'b1;
            r_next.soft_num = soft_trap_num_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    logic [2:0] cur_ch;
    logic [7:0] cur_cnt;
    logic cur_cont;
    assign cur_ch = r_reg.chn[r_reg.node];
    assign cur_cnt = r_reg.ccnt[cur_ch];
    assign cur_cont = r_reg.cctl[cur_ch][`CH_CONT];

    property p_branch_one;
        @(posedge clock_in) disable iff (sys_rst_in)
        branch_out |=> !branch_out && !xfer_out;
    endproperty
    a_branch_one: assert property (p_branch_one)
        else $error("branch pulse longer than one cycle");

    property p_xfer_steal;
        @(posedge clock_in) disable iff (sys_rst_in)
        xfer_out |-> !branch_out ##1 !xfer_out;
    endproperty
    a_xfer_steal: assert property (p_xfer_steal)
        else $error("transfer not a single stolen cycle");

    property p_latency;
        @(posedge clock_in) disable iff (sys_rst_in)
        r_reg.st == intc_pkg::WAIT && r_reg.cnt == 4'h0
        |=> branch_out || xfer_out;
    endproperty
    a_latency: assert property (p_latency)
        else $error("service did not start at end of latency");

    property p_count_dec;
        @(posedge clock_in) disable iff (sys_rst_in)
        xfer_out && !cur_cont && !reg_wr_in
        |=> cur_cnt == $past(cur_cnt) - 8'h01;
    endproperty
    a_count_dec: assert property (p_count_dec)
        else $error("transfer count not decremented");

    property p_count_hold;
        @(posedge clock_in) disable iff (sys_rst_in)
        xfer_out && cur_cont && !reg_wr_in
        |=> cur_cnt == $past(cur_cnt);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("continuous transfer changed the count");

    property p_terminal;
        @(posedge clock_in) disable iff (sys_rst_in)
        xfer_out && !cur_cont && cur_cnt == 8'h01 && !reg_wr_in
        |=> r_reg.req[r_reg.node] && !r_reg.xsel[r_reg.node];
    endproperty
    a_terminal: assert property (p_terminal)
        else $error("terminal count gave no standard request");

    property p_trap_block;
        @(posedge clock_in) disable iff (sys_rst_in)
        r_reg.tact && r_reg.st == intc_pkg::IDLE
        |=> r_reg.st != intc_pkg::WAIT;
    endproperty
    a_trap_block: assert property (p_trap_block)
        else $error("interrupt accepted during trap service");

    property p_trap_flag;
        @(posedge clock_in) disable iff (sys_rst_in)
        |trap_in |=> (r_reg.trap_flag_register[5:0] & $past(trap_in)) == $past(trap_in);
    endproperty
    a_trap_flag: assert property (p_trap_flag)
        else $error("trap event did not set its flag");

endmodule // interrupt_and_event_transfer_system
`default_nettype wire

// *** verification/cpu_model.sv ***
/*
 CPU core model at the service side: ends each trap service after a
 set number of cycles. Assumes one clock and an active high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Trap service handshake
    input wire logic trap_active_in,
    input wire logic [7:0] ret_delay_in,
    output logic trap_ret_out
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0] wait_reg;

    // Count service cycles, return once at the set delay
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wait_reg <= 8'h00;
            trap_ret_out <= 1'b0;
        end else begin
            trap_ret_out <= trap_active_in && wait_reg == ret_delay_in;
            wait_reg <= trap_active_in ? wait_reg + 8'h01 : 8'h00;
        end
    end
endmodule // cpu_model
`default_nettype wire

// *** verification/tb_top.sv ***
/*
 Self-checking bench of the interrupt and event transfer system.
 Assumes intc_defines.svh and the CPU model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "intc_defines.svh"
module tb_top;
    typedef struct {logic [41:0] v; int c;} note_t;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rdf = 1'b0;
    logic jc = 1'b1;
    logic [3:0] lvl = 4'h0;
    logic [6:0] snum = 7'h00;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] lf = 16'h0063;
    logic [129:0] srcv = 130'h0;
    logic [15:0] rdata, xs, xd;
    logic [7:0] vec;
    logic br, tact, xf, xb, irq, ret;
    note_t sq[$];
    logic [15:0] rq[$];
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    int wc = 0;

    always #2 clock_in = ~clock_in;

    interrupt_and_event_transfer_system dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .src_req_in(srcv[103:0]), .shared_src_in(srcv[115:104]),
        .eru_pin_in(srcv[129:126]), .esr_pin_in(srcv[124:122]),
        .cpu_level_in(lvl), .jump_cache_in(jc), .trap_in(srcv[121:116]),
        .trap_ret_in(ret), .soft_trap_in(srcv[125]),
        .soft_trap_num_in(snum), .branch_out(br), .vector_out(vec),
        .trap_active_out(tact), .xfer_out(xf), .xfer_src_out(xs),
        .xfer_dst_out(xd), .xfer_byte_out(xb), .irq_out(irq));

    cpu_model cpu (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .trap_active_in(tact), .ret_delay_in(8'hC8), .trap_ret_out(ret));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nx(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic conclude;
        $display("counts: %0d checked, %0d errors", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp(input logic [41:0] e, input logic [41:0] g);
        checked++;
        if (e !== g) begin
            errors++;
            $display("mismatch at %0t: expected %0h got %0h", $time, e, g);
        end
    endtask

    // Register port cycles, one idle cycle between strobes
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_in);
        reg_wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock_in);
        wc = cyc;
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        rq.push_back(e);
        @(posedge clock_in);
        reg_rd <= 1'b1;
        addr <= a;
        @(posedge clock_in);
        reg_rd <= 1'b0;
    endtask

    // One cycle pulse on a request, trap or pin line
    task automatic pulse(input int n);
        @(posedge clock_in);
        srcv[n] <= 1'b1;
        @(posedge clock_in);
        wc = cyc;
        srcv[n] <= 1'b0;
    endtask

    task automatic expb(input logic [7:0] v, input int c);
        sq.push_back('{{34'h0, v}, c});
    endtask

    task automatic expx(input logic [15:0] s, d, input logic b, int c);
        sq.push_back('{{1'b1, b, s, d, 8'h00}, c});
    endtask

    // Bounded wait for all notes, optionally for the trap return
    task automatic drain(input string s, input bit t);
        for (int i = 0; i < 400 && (sq.size() + rq.size() > 0 ||
             (t && tact !== 1'b0)); i++)
            @(posedge clock_in);
        if (sq.size() + rq.size() > 0 || (t && tact !== 1'b0)) begin
            errors++;
            conclude();
        end
        repeat (20) @(posedge clock_in);
        $display("test %0s done", s);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Monitor: oldest note against each read or service pulse
    always @(posedge clock_in) begin
        logic [41:0] g;
        note_t n;
        cyc <= cyc + 1;
        rdf <= reg_rd;
        g = xf === 1'b1 ? {1'b1, xb, xs, xd, 8'h00} : {34'h0, vec};
        n = '{~42'h0, -1};
        if (rdf && rq.size() > 0) n.v = 42'(rq.pop_front());
        if (rdf) cmp(n.v, 42'(rdata));
        n = '{~42'h0, -1};
        if ((br === 1'b1 || xf === 1'b1) && sq.size() > 0) n = sq.pop_front();
        if (br === 1'b1 || xf === 1'b1) begin
            cmp(n.v, g);
            if (n.c >= 0) cmp(42'(n.c), 42'(cyc));
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        rd(8'h00, 16'h0000);
        rd(8'h78, 16'h0000);
        rd(`A_TRAP, 16'h0000);
        drain("reset", 0);
        for (int j = 0; j < 2; j++) begin
            jc <= j[0];
            wr(8'h05, 16'h00C3);
            expb(8'h05, wc + (j ? 8 : 12));
            drain("latency", 0);
        end
        rd(8'h05, 16'h0043);
        lvl <= 4'h4;
        wr(8'h0A, 16'h00C3);
        wr(8'h14, 16'h00C6);
        expb(8'h14, wc + 8);
        drain("priority", 0);
        expb(8'h0A, -1);
        lvl <= 4'h0;
        drain("level", 0);
        wr(8'h1E, 16'h0045);
        pulse(30);
        expb(8'h1E, wc + 8);
        drain("dedicated", 0);
        wr(8'h70, 16'h0003);
        wr(8'h68, 16'h0045);
        pulse(107);
        expb(8'h68, wc + 8);
        drain("sources", 0);
        wr(`A_MASK, 16'h00FE);
        for (int c = 0; c < 8; c++) begin
            lf = nx(lf);
            wr(8'(8'h80 + 4 * c), 16'h0003);
            wr(8'(8'h81 + 4 * c), 16'h0001);
            wr(8'(8'h82 + 4 * c), lf);
            wr(8'(8'h83 + 4 * c), ~lf);
            wr(8'(40 + c), {4'h0, c[2:0], 1'b1, 8'h44});
            pulse(40 + c);
            expx(lf, ~lf, 1'b1, wc + 8);
            expb(8'(40 + c), -1);
            drain("channel", 0);
            cmp(42'(irq), 42'(c != 0));
            rd(`A_STAT, 16'h0001 << c);
            rd(`A_STAT, 16'h0000);
            rd(8'(8'h81 + 4 * c), 16'h0000);
            rd(8'(8'h82 + 4 * c), lf + 16'h0001);
            rd(8'(8'h83 + 4 * c), ~lf);
            drain("status", 0);
            cmp(42'(irq), 42'h0);
        end
        wr(8'h80, 16'h000E);
        wr(8'h81, 16'h0001);
        wr(8'h82, 16'h1000);
        wr(8'h83, 16'h2000);
        wr(8'h28, 16'h0144);
        for (int k = 0; k < 2; k++) begin
            pulse(40);
            expx(16'(16'h1000 + 2 * k), 16'(16'h2000 + 2 * k), 1'b0,
                 wc + 8);
            drain("continuous", 0);
        end
        rd(8'h81, 16'h0001);
        rd(8'h82, 16'h1004);
        expb(8'h82, -1);
        pulse(118);
        drain("trap", 0);
        cmp(42'(tact), 42'h1);
        rd(`A_TRAP, 16'h0004);
        wr(`A_TRAP, 16'h0004);
        expb(8'h84, -1);
        pulse(120);
        drain("nested trap", 0);
        wr(`A_TRAP, 16'h0010);
        wr(8'h32, 16'h00C5);
        expb(8'h32, -1);
        repeat (10) @(posedge clock_in);
        cmp(42'(sq.size()), 42'h1);
        drain("trap return", 1);
        for (int k = 0; k < 2; k++) begin
            wr(`A_ESR, k ? 16'h0010 : 16'h0001);
            expb(8'(8'h86 + k), -1);
            pulse(122 + k);
            drain("service pin", 0);
            wr(`A_TRAP, 16'(16'h0040 << k));
            drain("pin return", 1);
        end
        lf = nx(lf);
        snum <= lf[6:0];
        expb({1'b0, lf[6:0]}, -1);
        pulse(125);
        drain("soft trap", 0);
        wr(8'h71, 16'h000C);
        wr(8'h69, 16'h0045);
        wr(`A_EDGE, 16'h0001);
        wr(`A_ROUTE, 16'h0001);
        wr(`A_PATT, 16'h0001);
        for (int m = 3; m > 1; m--) begin
            wr(`A_GATE, 16'(m));
            if (m == 2) expb(8'h69, -1);
            pulse(126);
            drain("router", 0);
        end
        conclude();
    end
endmodule // tb_top
`default_nettype wire
